// [design/cwb_pkg.sv]
// Shared types and timing constants of the CAN wake and bias control block.
package cwb_pkg;
  localparam int unsigned CLK_MHZ = 200;
  // Wake filter: one 2 us bit at 500 kbps or two 1 us bits at 1 Mbps must pass.
  localparam int unsigned WK_FILTER_NS = 1000;
  localparam int unsigned WK_FILTER_CYC = (WK_FILTER_NS * CLK_MHZ) / 1000;
  localparam int unsigned WK_TIMEOUT_US = 1800;
  localparam int unsigned WK_TIMEOUT_CYC = WK_TIMEOUT_US * CLK_MHZ;
  localparam int unsigned SILENCE_US = 600000;
  localparam int unsigned SILENCE_CYC = SILENCE_US * CLK_MHZ;
  localparam int unsigned CNT_W = 32;

  typedef enum logic [2:0] {
    CWB_MODE_NORMAL = 3'h0,
    CWB_MODE_SILENT = 3'h1,
    CWB_MODE_STANDBY = 3'h2,
    CWB_MODE_GOTOSLEEP = 3'h3,
    CWB_MODE_SLEEP = 3'h4
  } cwb_mode_e;

  typedef enum logic [1:0] {
    CWB_BIAS_OFF = 2'h0,
    CWB_BIAS_AUTO_INACTIVE = 2'h1,
    CWB_BIAS_AUTO_ACTIVE = 2'h2,
    CWB_BIAS_ACTIVE = 2'h3
  } cwb_bias_e;

  typedef enum logic [1:0] {
    CWB_WK_IDLE = 2'h0,
    CWB_WK_DOM1 = 2'h1,
    CWB_WK_REC = 2'h2,
    CWB_WK_DOM2 = 2'h3
  } cwb_wake_e;

  // Comparator results: *_low is below the falling level, *_high above the rising one.
  typedef struct packed {
    logic battery_low;
    logic battery_high;
    logic transceiver_low;
    logic transceiver_high;
    logic io_low;
    logic io_high;
  } cwb_supply_s;

  typedef struct packed {
    logic dominant;
    logic rx_level;
    logic rx_oe;
  } cwb_line_s;
endpackage : cwb_pkg

// [design/cwb_ctrl.sv]
// Wake detection, autonomous bias state machine and driver/receiver gating.
`timescale 1ns/1ps
`default_nettype none

// Operation
// [R01] Wake needs dominant, recessive, dominant filtered phases.
// [R02] Phases under minimum filter never count.
// [R03] Phases over maximum filter always count.
// [R04] Pattern must finish within timeout, else reset.
// [R05] Remote node resumes recessive after dominant timeout.
// [R06] Filter passes 500 kbps bit or two 1 Mbps.
// [R07] Local wake on either wake input edge.
// [R08] Local wake on in sleep, off in normal.
// [R09] Battery undervoltage forces off; recovery to inactive.
// [R10] Inactive grounds bus; remote wake goes active.
// [R11] Silence expiry in low power drops to inactive.
// [R12] Leaving normal picks bias by silence time.
// [R13] Supply undervoltage drops active to autonomous active.
// [R14] Normal request with low supply gives autonomous.
// [R15] Active state only entering normal, supplies good.
// [R16] Transmit low before standby exit blocks driver.
// [R17] Normal: low transmit drives dominant, receive passes.
// [R18] Silent: driver off, receiver works.
// [R19] Standby: receive high unless wake pending.
// [R20] Second dominant drives receive low once I/O valid.
// [R21] Dominant is logic low on transmit and receive.
// [R22] Filter, timeout, silence are build-time counts.
// [R23] Detector ignores traffic, resets on timeout or mode.
module cwb_ctrl #(
  parameter int unsigned FILTER_CYCLES = cwb_pkg::WK_FILTER_CYC,
  parameter int unsigned TIMEOUT_CYCLES = cwb_pkg::WK_TIMEOUT_CYC,
  parameter int unsigned SILENCE_CYCLES = cwb_pkg::SILENCE_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire cwb_pkg::cwb_mode_e mode,
  input wire cwb_pkg::cwb_supply_s supply,
  input wire logic bus_dominant,
  input wire logic tx_data,
  input wire logic wake_pin,
  output cwb_pkg::cwb_bias_e bias_state,
  output cwb_pkg::cwb_line_s line,
  output logic wake_request_flag,
  output logic remote_wake_pattern,
  output logic local_wake_request,
  output logic transmit_stuck_low_guard
);
  import cwb_pkg::*;

  // Count limits are fixed at build time through the parameters. [R22]
  localparam logic [CNT_W-1:0] FILT_MAX = CNT_W'(FILTER_CYCLES);
  localparam logic [CNT_W-1:0] TMO_MAX = CNT_W'(TIMEOUT_CYCLES);
  localparam logic [CNT_W-1:0] SIL_MAX = CNT_W'(SILENCE_CYCLES);

  function automatic logic is_low_power(input cwb_mode_e m);
    is_low_power = (m == CWB_MODE_STANDBY) || (m == CWB_MODE_GOTOSLEEP)
                   || (m == CWB_MODE_SLEEP);
  endfunction : is_low_power

  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v,
                                               input logic [CNT_W-1:0] lim);
    sat_inc = (v >= lim) ? lim : v + CNT_W'(1);
  endfunction : sat_inc

  cwb_wake_e wk_q;
  cwb_bias_e bias_q;
  cwb_mode_e mode_q;
  logic [CNT_W-1:0] filt_q;
  logic [CNT_W-1:0] tmo_q;
  logic [CNT_W-1:0] sil_q;
  logic bus_q;
  logic wake_pin_q;
  logic wake_pend_q;
  logic rwk_q;
  logic lwk_q;
  logic tx_low_seen_q;
  logic guard_q;
  logic sep_q;
  logic low_power;
  logic filtered;
  logic timed_out;
  logic silence_exp;
  logic supplies_low;
  logic supplies_good;
  logic remote_hit;
  logic local_hit;

  assign low_power = is_low_power(mode);
  // A phase counts only once the bus held one state for the full filter count,
  // so shorter phases are never seen and longer ones always are. [R02] [R03] [R06]
  assign filtered = (filt_q >= FILT_MAX) && (bus_q == bus_dominant);
  assign timed_out = (wk_q != CWB_WK_IDLE) && (tmo_q >= TMO_MAX);
  assign silence_exp = (sil_q >= SIL_MAX);
  assign supplies_low = supply.transceiver_low || supply.io_low;
  assign supplies_good = supply.transceiver_high && supply.io_high;
  assign remote_hit = (wk_q == CWB_WK_DOM2) && filtered && bus_dominant && !timed_out;
  // Either edge of the wake input is a request; off in normal and silent. [R07] [R08]
  assign local_hit = low_power && (wake_pin != wake_pin_q);

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      bus_q <= 1'b0;
      filt_q <= '0;
    end
    else
    begin
      bus_q <= bus_dominant;
      if (bus_dominant != bus_q)
        filt_q <= CNT_W'(1);
      else
        filt_q <= sat_inc(filt_q, FILT_MAX);
    end
  end

  // Three filtered phases in order; other traffic is ignored between them,
  // and only a timeout or leaving the low-power modes resets the hunt. [R01] [R23]
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wk_q <= CWB_WK_IDLE;
    else if (!low_power || timed_out)
      wk_q <= CWB_WK_IDLE; // [R04] [R23]
    else
    begin
      unique case (wk_q)
        CWB_WK_IDLE:
        begin
          if (filtered && bus_dominant && !sep_q)
            wk_q <= CWB_WK_DOM1; // [R01] [R05]
        end
        CWB_WK_DOM1:
        begin
          if (filtered && !bus_dominant)
            wk_q <= CWB_WK_REC; // [R01]
        end
        CWB_WK_REC:
        begin
          if (filtered && bus_dominant)
            wk_q <= CWB_WK_DOM2; // [R01]
        end
        CWB_WK_DOM2:
        begin
          wk_q <= CWB_WK_IDLE;
        end
      endcase
    end
  end

  // Set when the window runs out on a dominant bus, so that a dominant phase
  // begun before the timeout can never open the next pattern. [R04] [R05]
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sep_q <= 1'b0;
    else if (timed_out && bus_dominant)
      sep_q <= 1'b1;
    else if (!low_power || (filtered && !bus_dominant))
      sep_q <= 1'b0;
  end

  // The window opens with the first filtered dominant phase. After a timeout
  // with the bus still dominant, the counter restarts only after a fresh
  // filtered recessive, which the remote node must supply. [R04] [R05]
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      tmo_q <= '0;
    else if (wk_q == CWB_WK_IDLE)
      tmo_q <= '0;
    else
      tmo_q <= sat_inc(tmo_q, TMO_MAX); // [R04]
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      wake_pin_q <= 1'b0;
      rwk_q <= 1'b0;
      lwk_q <= 1'b0;
    end
    else
    begin
      wake_pin_q <= wake_pin;
      rwk_q <= (wk_q == CWB_WK_DOM1 || wk_q == CWB_WK_REC) ? 1'b0 : remote_hit;
      lwk_q <= local_hit; // [R07]
    end
  end

  // Pending wake is set by either source and cleared on entering normal mode;
  // a new wake in the clearing cycle wins.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      wake_pend_q <= 1'b0;
    else if (remote_hit || local_hit)
      wake_pend_q <= 1'b1; // [R20]
    else if (mode == CWB_MODE_NORMAL)
      wake_pend_q <= 1'b0;
  end

  // Bus inactivity timer; any dominant bus restarts it.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      sil_q <= '0;
    else if (bus_dominant)
      sil_q <= '0;
    else
      sil_q <= sat_inc(sil_q, SIL_MAX);
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      bias_q <= CWB_BIAS_OFF;
    else if (supply.battery_low)
      bias_q <= CWB_BIAS_OFF; // [R09]
    else
    begin
      unique case (bias_q)
        CWB_BIAS_OFF:
        begin
          if (supply.battery_high)
            bias_q <= CWB_BIAS_AUTO_INACTIVE; // [R09]
        end
        CWB_BIAS_AUTO_INACTIVE:
        begin
          if (remote_hit)
            bias_q <= CWB_BIAS_AUTO_ACTIVE; // [R10]
          else if (!low_power && supplies_low)
            bias_q <= CWB_BIAS_AUTO_ACTIVE; // [R14]
          else if (mode == CWB_MODE_NORMAL && supplies_good)
            bias_q <= CWB_BIAS_ACTIVE; // [R15]
          else if (!low_power)
            bias_q <= CWB_BIAS_AUTO_ACTIVE; // [R14]
        end
        CWB_BIAS_AUTO_ACTIVE:
        begin
          if (low_power && silence_exp)
            bias_q <= CWB_BIAS_AUTO_INACTIVE; // [R11]
          else if (mode == CWB_MODE_NORMAL && supplies_good && !supplies_low)
            bias_q <= CWB_BIAS_ACTIVE; // [R15]
        end
        CWB_BIAS_ACTIVE:
        begin
          if (supplies_low)
            bias_q <= CWB_BIAS_AUTO_ACTIVE; // [R13]
          else if (low_power)
            bias_q <= silence_exp ? CWB_BIAS_AUTO_INACTIVE
                                  : CWB_BIAS_AUTO_ACTIVE; // [R12]
        end
      endcase
    end
  end

  // Transmit input low while still in standby arms the guard on leaving the
  // low-power modes; a stuck-low input cannot then jam the bus. The guard lifts
  // at the first recessive transmit level.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      mode_q <= CWB_MODE_SLEEP;
      tx_low_seen_q <= 1'b0;
      guard_q <= 1'b0;
    end
    else
    begin
      mode_q <= mode;
      if (low_power)
        tx_low_seen_q <= !tx_data;
      if (tx_data)
        guard_q <= 1'b0;
      else if (is_low_power(mode_q) && !low_power && tx_low_seen_q)
        guard_q <= 1'b1; // [R16]
    end
  end

  // Driver and receiver outputs follow the mode; dominant is logic low. [R21]
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
      line <= '{dominant: 1'b0, rx_level: 1'b1, rx_oe: 1'b0};
    else
    begin
      line.dominant <= (mode == CWB_MODE_NORMAL) && (bias_q == CWB_BIAS_ACTIVE)
                       && !tx_data && !guard_q && !(guard_q == 1'b0 &&
                       is_low_power(mode_q) && tx_low_seen_q); // [R16] [R17] [R18]
      // Receive output is driven only with a valid I/O supply, which defers
      // the wake indication until that supply rises. [R20]
      line.rx_oe <= supply.io_high && !supply.battery_low;
      unique case (mode)
        CWB_MODE_NORMAL, CWB_MODE_SILENT:
          line.rx_level <= !bus_dominant; // [R17] [R18]
        CWB_MODE_STANDBY:
          line.rx_level <= !wake_pend_q; // [R19] [R20]
        default:
          line.rx_level <= 1'b1;
      endcase
    end
  end

  assign bias_state = bias_q;
  assign wake_request_flag = wake_pend_q;
  assign remote_wake_pattern = rwk_q;
  assign local_wake_request = lwk_q;
  assign transmit_stuck_low_guard = guard_q;
endmodule : cwb_ctrl

`default_nettype wire

// [dv/cwb_ctrl_chk.sv]
// Concurrent checks on the wake and bias control ports.
`timescale 1ns/1ps
`default_nettype none
module cwb_ctrl_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire cwb_pkg::cwb_mode_e mode,
  input wire cwb_pkg::cwb_supply_s supply,
  input wire logic tx_data,
  input wire cwb_pkg::cwb_bias_e bias_state,
  input wire cwb_pkg::cwb_line_s line,
  input wire logic wake_request_flag,
  input wire logic remote_wake_pattern,
  input wire logic local_wake_request,
  input wire logic transmit_stuck_low_guard
);
  import cwb_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wake_pulse_a: assert property (remote_wake_pattern |=> !remote_wake_pattern)
    else $error("remote wake pulse too long");
  wake_flag_a: assert property (remote_wake_pattern |-> wake_request_flag)
    else $error("wake flag missing");
  local_off_a: assert property (local_wake_request |->
    !($past(mode) inside {CWB_MODE_NORMAL, CWB_MODE_SILENT}))
    else $error("local wake outside low power");
  drive_mode_a: assert property (line.dominant |->
    $past(mode) == CWB_MODE_NORMAL && !$past(tx_data))
    else $error("driver on without cause");
  active_entry_a: assert property ($changed(bias_state)
    && bias_state == CWB_BIAS_ACTIVE |-> $past(mode) == CWB_MODE_NORMAL
    && $past(supply.transceiver_high) && $past(supply.io_high))
    else $error("bad active entry");
  battery_off_a: assert property (supply.battery_low |=> bias_state == CWB_BIAS_OFF)
    else $error("no bias off on low battery");
  supply_drop_a: assert property (bias_state == CWB_BIAS_ACTIVE && !supply.battery_low
    && (supply.transceiver_low || supply.io_low) |=> bias_state == CWB_BIAS_AUTO_ACTIVE)
    else $error("no drop on low supply");
  guard_block_a: assert property (transmit_stuck_low_guard |-> !line.dominant)
    else $error("driver on while guarded");
endmodule : cwb_ctrl_chk
bind cwb_ctrl cwb_ctrl_chk u_chk (.sys_clk(sys_clk), .rst(rst), .mode(mode), .supply(supply),
  .tx_data(tx_data), .bias_state(bias_state), .line(line),
  .wake_request_flag(wake_request_flag), .remote_wake_pattern(remote_wake_pattern),
  .local_wake_request(local_wake_request), .transmit_stuck_low_guard(transmit_stuck_low_guard));
`default_nettype wire

// [dv/cwb_bus_node.sv]
// Remote bus node that plays dominant, recessive, dominant phases.
`timescale 1ns/1ps
`default_nettype none
module cwb_bus_node (
  input wire logic sys_clk,
  input wire logic start,
  input wire logic [31:0] ph,
  input wire logic [31:0] gap,
  input wire logic node_dom,
  output logic bus_dominant
);
  int unsigned k = 0;
  // Once the count runs out the node stays recessive, which separates patterns.
  always @(posedge sys_clk)
    k <= start ? 2 * ph + gap : (k != 0 ? k - 1 : 0);
  // Wired-AND bus: any node driving dominant wins.
  assign bus_dominant = (k > ph + gap) || (k != 0 && k <= ph) || node_dom;
endmodule : cwb_bus_node
`default_nettype wire

// [dv/can_wake_and_bias_control_tb_top.sv]
// Self-checking bench for the CAN wake and bias control block.
`timescale 1ns/1ps
`default_nettype none
module can_wake_and_bias_control_tb_top;
  import cwb_pkg::*;
  localparam int unsigned FILT = 4;
  logic sys_clk = 1'h0;
  logic rst = 1'h1;
  cwb_mode_e mode = CWB_MODE_STANDBY;
  cwb_supply_s supply = 6'h20;
  logic tx_data = 1'h1;
  logic wake_pin = 1'h0;
  logic start = 1'h0;
  int unsigned ph = 0;
  int unsigned gap = 0;
  logic bus_dominant, flag, rwp, lwr, guard, prev_tx, prev_bus;
  cwb_bias_e bias_state;
  cwb_line_s line;
  logic [7:0] seed = 8'h2A;
  int bad_count = 0;
  int comparisons = 0;
  int rwp_n = 0;
  int lwr_n = 0;
  cwb_ctrl #(.FILTER_CYCLES(FILT), .TIMEOUT_CYCLES(64), .SILENCE_CYCLES(200)) u_dut (
    .sys_clk(sys_clk), .rst(rst), .mode(mode), .supply(supply),
    .bus_dominant(bus_dominant), .tx_data(tx_data), .wake_pin(wake_pin),
    .bias_state(bias_state), .line(line), .wake_request_flag(flag),
    .remote_wake_pattern(rwp), .local_wake_request(lwr), .transmit_stuck_low_guard(guard));
  cwb_bus_node u_node (.sys_clk(sys_clk), .start(start), .ph(ph), .gap(gap),
    .node_dom(line.dominant), .bus_dominant(bus_dominant));
  initial
    forever #2.5 sys_clk = ~sys_clk;
  // Pulses are counted here since each stands for one cycle only.
  always @(posedge sys_clk)
  begin
    if (rwp === 1'h1) rwp_n++;
    if (lwr === 1'h1) lwr_n++;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  task automatic print_verdict();
    if (bad_count == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : print_verdict
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask : cyc
  task automatic wait_bias(input cwb_bias_e e);
    int i;
    for (i = 0; i < 20 && bias_state !== e; i++) cyc(1);
    check(bias_state, e);
    if (i == 20) print_verdict();
  endtask : wait_bias
  task automatic pattern(input int unsigned p, input int unsigned g);
    ph = p;
    gap = g;
    start = 1'h1;
    cyc(1);
    start = 1'h0;
    cyc(2 * p + g + 6);
  endtask : pattern
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    bad_count++;
    print_verdict();
  end
  initial
  begin
    cyc(5);
    rst = 1'h0;
    check(line, 3'h2);
    cyc(3);
    check(bias_state, CWB_BIAS_OFF);
    supply = 6'h15;
    wait_bias(CWB_BIAS_AUTO_INACTIVE);
    pattern(FILT - 1, FILT - 1);
    check(rwp_n, 32'h0);
    pattern(FILT + 3, 80);
    cyc(80);
    check(rwp_n, 32'h0);
    pattern(FILT + 3, FILT + 3);
    check(rwp_n, 32'h1);
    check(bias_state, CWB_BIAS_AUTO_ACTIVE);
    check(line.rx_level, 1'h0);
    check(flag, 1'h1);
    check(line.rx_oe, 1'h1);
    mode = CWB_MODE_SLEEP;
    wake_pin = 1'h1;
    cyc(3);
    check(lwr_n, 32'h1);
    tx_data = 1'h0;
    cyc(1);
    mode = CWB_MODE_NORMAL;
    wait_bias(CWB_BIAS_ACTIVE);
    check(flag, 1'h0);
    check(guard, 1'h1);
    cyc(2);
    check(line.dominant, 1'h0);
    wake_pin = 1'h0;
    tx_data = 1'h1;
    cyc(3);
    check(lwr_n, 32'h1);
    prev_tx = tx_data;
    prev_bus = bus_dominant;
    cyc(1);
    repeat (24)
    begin
      check(line.dominant, !prev_tx);
      check(line.rx_level, !prev_bus);
      seed = lfsr(seed);
      tx_data = seed[0];
      prev_tx = tx_data;
      prev_bus = bus_dominant;
      cyc(1);
    end
    mode = CWB_MODE_SILENT;
    tx_data = 1'h0;
    ph = FILT;
    gap = 0;
    start = 1'h1;
    cyc(1);
    start = 1'h0;
    cyc(2);
    check(line.dominant, 1'h0);
    check(line.rx_level, 1'h0);
    mode = CWB_MODE_NORMAL;
    supply = 6'h16;
    wait_bias(CWB_BIAS_AUTO_ACTIVE);
    supply = 6'h15;
    wait_bias(CWB_BIAS_ACTIVE);
    cyc(4);
    tx_data = 1'h1;
    mode = CWB_MODE_STANDBY;
    wait_bias(CWB_BIAS_AUTO_ACTIVE);
    cyc(200);
    wait_bias(CWB_BIAS_AUTO_INACTIVE);
    supply = 6'h16;
    mode = CWB_MODE_NORMAL;
    cyc(4);
    check(bias_state, CWB_BIAS_AUTO_ACTIVE);
    supply = 6'h15;
    wait_bias(CWB_BIAS_ACTIVE);
    mode = CWB_MODE_STANDBY;
    wait_bias(CWB_BIAS_AUTO_INACTIVE);
    supply = 6'h20;
    wait_bias(CWB_BIAS_OFF);
    check(line.rx_oe, 1'h0);
    print_verdict();
  end
endmodule : can_wake_and_bias_control_tb_top
`default_nettype wire
